// *** core/cit_core.sv ***
// instruction timing core: arithmetic group, conditional branch timing,
// external and code space moves
// assumes fetched operands on ins, memory answering one clock after a request
`timescale 1ns/1ps
module cit_core
	import cit_pkg::*;
#(
	parameter int unsigned CLK_HZ = CIT_CLK_HZ_MAX,
	parameter int unsigned CNT_W = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// instruction handoff
	input wire logic ins_valid,
	input wire cit_instr_type ins,
	input wire logic [15:0] pc,
	input wire logic [15:0] dptr,
	output logic ins_ready,
	// program store control
	input wire logic [1:0] program_store_control,
	// memory port
	output logic mem_req,
	output cit_mem_type mem,
	input wire logic [7:0] mem_rdata,
	// results
	output logic retire,
	output logic [3:0] cycles_used,
	output logic [7:0] acc,
	output cit_flags_type program_status_word,
	output logic wb_valid,
	output logic [7:0] wb_data,
	output logic redirect,
	output logic [7:0] rel,
	output logic foreign
);

	if (CLK_HZ > CIT_CLK_HZ_MAX) begin : g_clk_chk
		$error("system clock above supported maximum"); // RQ7
	end
	if ((2 ** CNT_W) <= CIT_CYC_MAX) begin : g_cnt_chk
		$error("cycle counter too narrow for longest instruction"); // RQ5
	end

	cit_state_type state_q, state_d;
	cit_instr_type ins_q;
	cit_dec_type dec;
	logic [CNT_W-1:0] cnt_q;
	logic [3:0] total_q;
	logic ready_q, retire_q, mem_req_q, wb_valid_q, redirect_q, foreign_q;
	logic [3:0] cycles_q;
	logic [7:0] acc_q, wb_q, rel_q;
	cit_flags_type flags_q;
	cit_mem_type mem_q;

	// the decoder sees the live opcode while idle, the held one while busy
	wire busy = (state_q == CIT_ST_EXEC);
	wire cit_instr_type cur = busy ? ins_q : ins;

	cit_decode u_dec (
		.op(cur.op),
		.dec(dec)
	);

	// offers while busy are ignored, never queued
	wire accept = ins_valid && ready_q && !busy;

	// branch condition from the current accumulator and carry
	wire cond = (cur.op == CIT_OP_JC) ? flags_q.cy :
		(cur.op == CIT_OP_JNC) ? !flags_q.cy :
		(cur.op == CIT_OP_JZ) ? (acc_q == 8'h00) : (acc_q != 8'h00);
	wire taken = (dec.kind == CIT_K_BRANCH) && cond;
	wire [3:0] total = dec.cyc + {3'h0, taken}; // RQ4
	// one-clock work commits at the taking edge itself
	wire finish_now = accept && (total == CIT_CYC_1);
	wire finish_late = busy && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
	wire commit = finish_now || finish_late; // RQ2 RQ3

	// arithmetic datapath, flags as in the standard set
	wire [7:0] opa = acc_q;
	wire [7:0] opb = dec.on_acc ? acc_q : dec.imm ? cur.b1 : cur.src;
	wire cin = ((dec.alu == CIT_ALU_ADD_CY) || (dec.alu == CIT_ALU_SUB_BR)) ? flags_q.cy : 1'b0;
	wire [8:0] sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
	wire [4:0] sum5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
	wire [7:0] sum8 = {1'b0, opa[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
	wire [8:0] dif9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
	wire [4:0] dif5 = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
	wire [7:0] dif8 = {1'b0, opa[6:0]} - {1'b0, opb[6:0]} - {7'h00, cin};
	wire is_sub = (dec.alu == CIT_ALU_SUB_BR);
	wire is_incdec = (dec.alu == CIT_ALU_INC) || (dec.alu == CIT_ALU_DEC);
	wire [7:0] step = (dec.alu == CIT_ALU_INC) ? opb + 8'h01 : opb - 8'h01;
	wire [7:0] ar_res = is_incdec ? step : is_sub ? dif9[7:0] : sum9[7:0];
	// carry, half carry and overflow; overflow is carry into bit 7 against out
	wire cit_flags_type ar_flags = is_sub ?
		cit_flags_type'{cy: dif9[8], ac: dif5[4], ov: dif9[8] ^ dif8[7]} :
		cit_flags_type'{cy: sum9[8], ac: sum5[4], ov: sum9[8] ^ sum8[7]}; // RQ1
	// increment and decrement leave the status word alone
	wire ar_to_acc = !is_incdec || dec.on_acc;

	// external move steering; code space read always goes to flash
	wire flash_sel = (dec.kind == CIT_K_CODERD) ? 1'b1 :
		dec.is_wr ? program_store_control[CIT_PSC_FLASH_WR_BIT] :
		program_store_control[CIT_PSC_FLASH_RD_BIT]; // RQ11 RQ12
	wire [15:0] base = (dec.kind == CIT_K_CODERD) ? (dec.use_dptr ? dptr : pc) :
		(dec.use_dptr ? dptr : {8'h00, cur.src});
	wire [15:0] xaddr = (dec.kind == CIT_K_CODERD) ? base + {8'h00, acc_q} : base;
	wire memop = (dec.kind == CIT_K_XMOVE) || (dec.kind == CIT_K_CODERD);
	wire mem_load = memop && !dec.is_wr;

	always_comb begin
		state_d = state_q;
		case (state_q)
			CIT_ST_IDLE: begin
				if (accept && !finish_now) begin
					state_d = CIT_ST_EXEC;
				end
			end
			CIT_ST_EXEC: begin
				if (finish_late) begin
					state_d = CIT_ST_IDLE;
				end
			end
			default: begin
				state_d = CIT_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= CIT_ST_IDLE;
			ins_q <= '0;
			cnt_q <= '0;
			total_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (accept) begin
				ins_q <= ins;
				total_q <= total;
				cnt_q <= CNT_W'(total - 4'h1); // RQ5
			end else if (busy) begin
				cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ready drops for all but the first clock of a multi-clock instruction
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ready_q <= 1'b1;
		end else begin
			ready_q <= (state_d == CIT_ST_IDLE); // RQ3
		end
	end

	// one byte per request, issued the clock after acceptance
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mem_req_q <= 1'b0;
			mem_q <= '0;
		end else begin
			mem_req_q <= accept && memop; // RQ13
			if (accept && memop) begin
				mem_q <= '{flash: flash_sel, we: dec.is_wr, addr: xaddr, wdata: acc_q};
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acc_q <= 8'h00;
			flags_q <= '0;
		end else if (commit && (dec.kind == CIT_K_ARITH)) begin
			if (ar_to_acc) begin
				acc_q <= ar_res;
			end
			if (!is_incdec) begin
				flags_q <= ar_flags; // RQ8 RQ9 RQ10
			end
		end else if (commit && mem_load) begin
			acc_q <= mem_rdata; // RQ12 RQ13
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			retire_q <= 1'b0;
			cycles_q <= 4'h0;
			wb_valid_q <= 1'b0;
			wb_q <= 8'h00;
			redirect_q <= 1'b0;
			rel_q <= 8'h00;
			foreign_q <= 1'b0;
		end else begin
			retire_q <= commit;
			wb_valid_q <= commit && (dec.kind == CIT_K_ARITH) && !ar_to_acc;
			redirect_q <= commit && taken;
			foreign_q <= commit && (dec.kind == CIT_K_FOREIGN); // RQ6
			if (commit) begin
				cycles_q <= finish_now ? total : total_q;
				wb_q <= ar_res;
				rel_q <= cur.b1;
			end
		end
	end

	// every output is a flop; no decode reaches a pin
	assign ins_ready = ready_q;
	assign mem_req = mem_req_q;
	assign mem = mem_q;
	assign retire = retire_q;
	assign cycles_used = cycles_q;
	assign acc = acc_q;
	assign program_status_word = flags_q;
	assign wb_valid = wb_valid_q;
	assign wb_data = wb_q;
	assign redirect = redirect_q;
	assign rel = rel_q;
	assign foreign = foreign_q;

endmodule

// *** core/cit_pkg.sv ***
// shared constants, opcode map and carrier types of the instruction timing core
// assumes one system clock; operands arrive already fetched from the pipeline
// What this block does
// RQ1 - opcodes, addressing forms and status flags match the standard 8-bit set
// RQ2 - every timing is counted in system clocks, no machine cycle
// RQ3 - most instructions take as many clocks as they have program bytes
// RQ4 - a conditional branch not taken finishes one clock before a taken one
// RQ5 - no instruction needs more than eight system clocks
// RQ6 - the full core decodes 109 distinct instructions; this block decodes 72 opcodes and flags every other one as foreign
// RQ7 - system clock from zero to 25MHz, one instruction per clock at peak
// RQ8 - add: register 1/1, direct and immediate 2/2, indirect 1/2
// RQ9 - add with carry: register 1/1, direct and immediate 2/2, indirect 1/2
// RQ10 - subtract with borrow: register 1/1, direct and immediate 2/2, indirect 1/2
// RQ11 - program store control bits steer the external move to program flash
// RQ12 - with data space selected the external move reaches external data ram
// RQ13 - software reads and changes flash one byte per access
package cit_pkg;

	localparam int unsigned CIT_CLK_HZ_MAX = 25_000_000;
	localparam int unsigned CIT_CYC_MAX = 8;
	localparam int unsigned CIT_INSTR_TOTAL = 109;

	localparam logic [3:0] CIT_CYC_1 = 4'h1;
	localparam logic [3:0] CIT_CYC_2 = 4'h2;
	localparam logic [3:0] CIT_CYC_3 = 4'h3;
	localparam logic [1:0] CIT_LEN_1 = 2'h1;
	localparam logic [1:0] CIT_LEN_2 = 2'h2;

	// program store control field positions
	localparam int unsigned CIT_PSC_FLASH_WR_BIT = 0;
	localparam int unsigned CIT_PSC_FLASH_RD_BIT = 1;

	// opcode rows and columns of the arithmetic group
	localparam logic [3:0] CIT_ROW_INC = 4'h0;
	localparam logic [3:0] CIT_ROW_DEC = 4'h1;
	localparam logic [3:0] CIT_ROW_ADD = 4'h2;
	localparam logic [3:0] CIT_ROW_ADD_CY = 4'h3;
	localparam logic [3:0] CIT_ROW_SUB_BR = 4'h9;
	localparam logic [3:0] CIT_COL_ACC = 4'h4;
	localparam logic [3:0] CIT_COL_DIR = 4'h5;
	localparam logic [3:0] CIT_COL_IND0 = 4'h6;
	localparam logic [3:0] CIT_COL_IND1 = 4'h7;

	localparam logic [7:0] CIT_OP_JC = 8'h40;
	localparam logic [7:0] CIT_OP_JNC = 8'h50;
	localparam logic [7:0] CIT_OP_JZ = 8'h60;
	localparam logic [7:0] CIT_OP_JNZ = 8'h70;
	localparam logic [7:0] CIT_OP_CODERD_DPTR = 8'h93;
	localparam logic [7:0] CIT_OP_CODERD_PC = 8'h83;
	localparam logic [7:0] CIT_OP_XRD_DPTR = 8'hE0;
	localparam logic [7:0] CIT_OP_XRD_R0 = 8'hE2;
	localparam logic [7:0] CIT_OP_XRD_R1 = 8'hE3;
	localparam logic [7:0] CIT_OP_XWR_DPTR = 8'hF0;
	localparam logic [7:0] CIT_OP_XWR_R0 = 8'hF2;
	localparam logic [7:0] CIT_OP_XWR_R1 = 8'hF3;

	typedef enum logic [4:0] {
		CIT_K_ARITH = 5'h01,
		CIT_K_BRANCH = 5'h02,
		CIT_K_XMOVE = 5'h04,
		CIT_K_CODERD = 5'h08,
		CIT_K_FOREIGN = 5'h10
	} cit_kind_type;

	typedef enum logic [2:0] {
		CIT_ALU_ADD = 3'h0,
		CIT_ALU_ADD_CY = 3'h1,
		CIT_ALU_SUB_BR = 3'h2,
		CIT_ALU_INC = 3'h3,
		CIT_ALU_DEC = 3'h4
	} cit_alu_type;

	typedef enum logic [1:0] {
		CIT_ST_IDLE = 2'h1,
		CIT_ST_EXEC = 2'h2
	} cit_state_type;

	typedef struct packed {
		logic [7:0] op;
		logic [7:0] b1;
		logic [7:0] src;
	} cit_instr_type;

	typedef struct packed {
		cit_kind_type kind;
		cit_alu_type alu;
		logic imm;
		logic on_acc;
		logic is_wr;
		logic use_dptr;
		logic [1:0] len;
		logic [3:0] cyc;
	} cit_dec_type;

	typedef struct packed {
		logic flash;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cit_mem_type;

	typedef struct packed {
		logic cy;
		logic ac;
		logic ov;
	} cit_flags_type;

endpackage

// *** core/cit_decode.sv ***
// opcode decoder: kind, operand form, length and base clock count
// assumes a pure combinational use by cit_core
`timescale 1ns/1ps
module cit_decode
	import cit_pkg::*;
(
	// opcode in
	input wire logic [7:0] op,
	// decoded fields out
	output cit_dec_type dec
);

	wire [3:0] row = op[7:4];
	wire [3:0] col = op[3:0];
	wire row_arith = (row == CIT_ROW_INC) || (row == CIT_ROW_DEC) || (row == CIT_ROW_ADD)
		|| (row == CIT_ROW_ADD_CY) || (row == CIT_ROW_SUB_BR);
	wire col_arith = (col >= CIT_COL_ACC);
	wire is_arith = row_arith && col_arith;
	wire incdec = (row == CIT_ROW_INC) || (row == CIT_ROW_DEC);
	wire f_acc = (col == CIT_COL_ACC);
	wire f_dir = (col == CIT_COL_DIR);
	wire f_ind = (col == CIT_COL_IND0) || (col == CIT_COL_IND1);
	wire is_branch = (op == CIT_OP_JC) || (op == CIT_OP_JNC) || (op == CIT_OP_JZ)
		|| (op == CIT_OP_JNZ);
	wire is_xrd = (op == CIT_OP_XRD_DPTR) || (op == CIT_OP_XRD_R0) || (op == CIT_OP_XRD_R1);
	wire is_xwr = (op == CIT_OP_XWR_DPTR) || (op == CIT_OP_XWR_R0) || (op == CIT_OP_XWR_R1);
	wire is_coderd = (op == CIT_OP_CODERD_DPTR) || (op == CIT_OP_CODERD_PC);
	// immediate shares the accumulator column on the add rows
	wire imm_form = f_acc && !incdec;
	wire two_byte = f_dir || imm_form;
	// indirect pays one extra clock over its single byte
	wire [3:0] ar_cyc = (two_byte || f_ind) ? CIT_CYC_2 : CIT_CYC_1; // RQ8 RQ9 RQ10
	wire [1:0] ar_len = two_byte ? CIT_LEN_2 : CIT_LEN_1; // RQ3
	wire cit_alu_type alu_sel = (row == CIT_ROW_INC) ? CIT_ALU_INC :
		(row == CIT_ROW_DEC) ? CIT_ALU_DEC :
		(row == CIT_ROW_ADD) ? CIT_ALU_ADD :
		(row == CIT_ROW_ADD_CY) ? CIT_ALU_ADD_CY : CIT_ALU_SUB_BR; // RQ1

	assign dec.kind = is_arith ? CIT_K_ARITH : is_branch ? CIT_K_BRANCH :
		(is_xrd || is_xwr) ? CIT_K_XMOVE : is_coderd ? CIT_K_CODERD : CIT_K_FOREIGN;
	assign dec.alu = alu_sel;
	assign dec.imm = imm_form;
	assign dec.on_acc = f_acc && incdec;
	assign dec.is_wr = is_xwr;
	assign dec.use_dptr = (col == 4'h0) || (op == CIT_OP_CODERD_DPTR);
	assign dec.len = is_arith ? ar_len : is_branch ? CIT_LEN_2 : CIT_LEN_1;
	// branch base is the not-taken count; the core adds one when taken
	assign dec.cyc = is_arith ? ar_cyc : is_branch ? CIT_CYC_2 :
		(is_xrd || is_xwr || is_coderd) ? CIT_CYC_3 : CIT_CYC_1; // RQ2 RQ4

endmodule

// *** tb/cit_core_sva.sv ***
// port timing checker for cit_core
// assumes one clock, reset low; bound below
`timescale 1ns/1ps
module cit_core_sva
	import cit_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// handoff
	input wire logic ins_valid,
	input wire cit_instr_type ins,
	input wire logic [15:0] dptr,
	input wire logic ins_ready,
	input wire logic [1:0] program_store_control,
	// results
	input wire logic mem_req,
	input wire cit_mem_type mem,
	input wire logic retire,
	input wire logic [3:0] cycles_used,
	input wire cit_flags_type program_status_word,
	input wire logic foreign
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire tk = ins_valid && ins_ready;
	property p_add_reg;
		tk && ins.op == 8'h28 |=> retire && cycles_used == 4'h1;
	endproperty
	a_add_reg: assert property (p_add_reg) else $error("add reg timing");
	property p_add_imm;
		tk && ins.op == 8'h24 |=> !retire && !ins_ready ##1 retire && cycles_used == 4'h2;
	endproperty
	a_add_imm: assert property (p_add_imm) else $error("add imm timing");
	property p_addcy_ind;
		tk && ins.op == 8'h36 |=> !retire ##1 retire && cycles_used == 4'h2;
	endproperty
	a_addcy_ind: assert property (p_addcy_ind) else $error("add carry ind timing");
	property p_sub_reg;
		tk && ins.op[7:3] == 5'h13 |=> retire && cycles_used == 4'h1;
	endproperty
	a_sub_reg: assert property (p_sub_reg) else $error("subtract reg timing");
	property p_br_not;
		tk && ins.op == 8'h40 && !program_status_word.cy |=> !retire ##1 retire
			&& cycles_used == 4'h2;
	endproperty
	a_br_not: assert property (p_br_not) else $error("branch not taken timing");
	property p_br_take;
		tk && ins.op == 8'h40 && program_status_word.cy |=> !retire [*2] ##1 retire
			&& cycles_used == 4'h3;
	endproperty
	a_br_take: assert property (p_br_take) else $error("branch taken timing");
	property p_xrd;
		tk && ins.op == 8'hE0 |=> mem_req && !mem.we
			&& mem.flash == $past(program_store_control[CIT_PSC_FLASH_RD_BIT])
			&& mem.addr == $past(dptr);
	endproperty
	a_xrd: assert property (p_xrd) else $error("external read request");
	property p_xdone;
		mem_req |=> !retire ##1 retire && cycles_used == 4'h3;
	endproperty
	a_xdone: assert property (p_xdone) else $error("memory access timing");
	property p_max;
		retire |-> cycles_used != 4'h0 && cycles_used <= 4'h8;
	endproperty
	a_max: assert property (p_max) else $error("cycle count range");
	property p_foreign;
		tk && ins.op == 8'h00 |=> foreign && retire && cycles_used == 4'h1;
	endproperty
	a_foreign: assert property (p_foreign) else $error("foreign opcode");
	c_three: cover property (retire && cycles_used == 4'h3);
	c_flash_wr: cover property (mem_req && mem.we && mem.flash);
	c_foreign: cover property (foreign);
endmodule
bind cit_core cit_core_sva u_sva (.mclk(mclk), .rstn(rstn), .ins_valid(ins_valid),
	.ins(ins), .dptr(dptr), .ins_ready(ins_ready),
	.program_store_control(program_store_control), .mem_req(mem_req), .mem(mem),
	.retire(retire), .cycles_used(cycles_used),
	.program_status_word(program_status_word), .foreign(foreign));

// *** tb/cit_mem_model.sv ***
// program flash and external data ram model
// decodes the low address byte only
`timescale 1ns/1ps
module cit_mem_model
	import cit_pkg::*;
(
	// clock
	input wire logic mclk,
	// request
	input wire logic mem_req,
	input wire cit_mem_type mem,
	// answer
	output logic [7:0] mem_rdata
);
	logic [7:0] fl [256];
	logic [7:0] dm [256];
	initial begin
		mem_rdata = 8'h5A;
		for (int i = 0; i < 256; i++) begin
			fl[i] = i[7:0] ^ 8'hA5;
			dm[i] = i[7:0];
		end
	end
	// valid one cycle only, toggles after so stale reads show
	always @(posedge mclk) begin
		if (mem_req && mem.we && mem.flash) fl[mem.addr[7:0]] <= mem.wdata;
		if (mem_req && mem.we && !mem.flash) dm[mem.addr[7:0]] <= mem.wdata;
		if (mem_req) mem_rdata <= mem.flash ? fl[mem.addr[7:0]] : dm[mem.addr[7:0]];
		else mem_rdata <= ~mem_rdata;
	end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for cit_core
// assumes cit_pkg, checker and memory model compiled first
`timescale 1ns/1ps
module testbench;
	import cit_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic ins_valid = 1'b0;
	cit_instr_type ins = '0;
	logic [15:0] dptr = 16'h0000;
	logic [15:0] pc = 16'h0000;
	logic [1:0] psc = 2'h0;
	logic ins_ready, mem_req, retire, redirect, foreign, wb_valid;
	cit_mem_type mem;
	logic [7:0] mem_rdata, acc, wb_data, rel;
	logic [3:0] cycles_used;
	cit_flags_type stat;
	int error_cnt = 0;
	int samples_checked = 0;
	int tick = 0;
	int n_cyc;
	logic saw_rd, saw_fr, saw_wb;
	logic cy_e = 1'b0;
	logic [7:0] acc_e = 8'h00;
	always #10 mclk = ~mclk;
	cit_core uut (.mclk(mclk), .rstn(rstn), .ins_valid(ins_valid), .ins(ins), .pc(pc),
		.dptr(dptr), .ins_ready(ins_ready), .program_store_control(psc), .mem_req(mem_req),
		.mem(mem), .mem_rdata(mem_rdata), .retire(retire), .cycles_used(cycles_used),
		.acc(acc), .program_status_word(stat), .wb_valid(wb_valid), .wb_data(wb_data),
		.redirect(redirect), .rel(rel), .foreign(foreign));
	cit_mem_model mdl (.mclk(mclk), .mem_req(mem_req), .mem(mem), .mem_rdata(mem_rdata));
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic issue(input logic [7:0] op, b1, src);
		int w;
		@(posedge mclk);
		ins_valid <= 1'b1;
		ins <= '{op: op, b1: b1, src: src};
		w = 0;
		do begin
			@(posedge mclk);
			w++;
		end while (!ins_ready && w < 20);
		ins_valid <= 1'b0;
		// a one-clock retire stands in the cycle right after the taking edge
		#1;
		n_cyc = 1;
		saw_rd = redirect;
		saw_fr = foreign;
		saw_wb = wb_valid;
		while (!retire && n_cyc < 12) begin
			@(posedge mclk);
			#1;
			n_cyc++;
			saw_rd |= redirect;
			saw_fr |= foreign;
			saw_wb |= wb_valid;
		end
	endtask
	task automatic arith(input logic [7:0] op, b1, src);
		logic [8:0] r;
		logic [4:0] h;
		logic [7:0] s;
		logic ci, sb, ov;
		s = (op[3:0] == CIT_COL_ACC) ? b1 : src;
		sb = (op[7:4] == CIT_ROW_SUB_BR);
		ci = (sb || op[7:4] == CIT_ROW_ADD_CY) ? cy_e : 1'b0;
		r = sb ? {1'b0, acc_e} - s - ci : {1'b0, acc_e} + s + ci;
		h = sb ? {1'b0, acc_e[3:0]} - s[3:0] - ci : {1'b0, acc_e[3:0]} + s[3:0] + ci;
		// signed overflow: operand signs agree for add, differ for subtract
		ov = (acc_e[7] ^ s[7] ^ sb) ? 1'b0 : (r[7] != acc_e[7]);
		issue(op, b1, src);
		acc_e = r[7:0];
		cy_e = r[8];
		chk("cycles", n_cyc[15:0], op[3] ? 16'h1 : 16'h2);
		chk("cycles_used", cycles_used, op[3] ? 16'h1 : 16'h2);
		chk("acc", acc, acc_e);
		chk("cy", stat.cy, cy_e);
		chk("ac", stat.ac, h[4]);
		chk("ov", stat.ov, ov);
	endtask
	task automatic t_arith;
		logic [3:0] rows [3] = '{CIT_ROW_ADD, CIT_ROW_ADD_CY, CIT_ROW_SUB_BR};
		logic [3:0] cols [6] = '{4'h8, 4'hF, CIT_COL_DIR, CIT_COL_ACC, CIT_COL_IND0, CIT_COL_IND1};
		foreach (rows[i]) foreach (cols[j]) arith({rows[i], cols[j]}, 8'h71, 8'h9C);
	endtask
	task automatic incdec(input logic [7:0] op, src, input int n);
		logic [7:0] v;
		v = (op[3:0] == CIT_COL_ACC) ? acc_e : src;
		v = op[4] ? v - 8'h01 : v + 8'h01;
		issue(op, 8'h00, src);
		chk("incdec_cycles", n_cyc[15:0], n[15:0]);
		chk("incdec_cy", stat.cy, cy_e);
		if (op[3:0] == CIT_COL_ACC) begin
			acc_e = v;
			chk("incdec_wb", saw_wb, 1'b0);
		end else begin
			chk("incdec_wb", saw_wb, 1'b1);
			chk("incdec_data", wb_data, v);
		end
		chk("incdec_acc", acc, acc_e);
	endtask
	task automatic t_incdec;
		incdec(8'h08, 8'h9C, 1);
		incdec(8'h15, 8'h00, 2);
		incdec(8'h04, 8'h00, 1);
		incdec(8'h17, 8'h10, 2);
	endtask
	task automatic t_carry;
		arith(8'h24, ~acc_e, 8'h00);
		arith(8'h24, 8'h01, 8'h00);
	endtask
	task automatic t_foreign;
		issue(8'h00, 8'h00, 8'h00);
		chk("foreign", saw_fr, 1'b1);
		chk("foreign_cycles", n_cyc[15:0], 16'h1);
	endtask
	task automatic t_branch;
		logic [7:0] ops [4] = '{CIT_OP_JC, CIT_OP_JNC, CIT_OP_JZ, CIT_OP_JNZ};
		logic tk;
		foreach (ops[i]) begin
			tk = ops[i][4] ^ (ops[i][5] ? acc_e == 8'h00 : cy_e);
			issue(ops[i], 8'h12, 8'h00);
			chk("branch_cycles", n_cyc[15:0], tk ? 16'h3 : 16'h2);
			chk("redirect", saw_rd, tk);
			chk("rel", rel, 8'h12);
		end
	endtask
	task automatic xm(input logic [1:0] sel, input logic [7:0] op, src, input logic [15:0] dp,
		input logic [7:0] exp);
		@(posedge mclk);
		psc <= sel;
		dptr <= dp;
		pc <= ~dp;
		issue(op, 8'h00, src);
		chk("xm_cycles", n_cyc[15:0], 16'h3);
		chk("xm_acc", acc, exp);
	endtask
	task automatic t_xmove;
		logic [7:0] x;
		x = acc_e;
		xm(2'h1, CIT_OP_XWR_R0, 8'h41, 16'h0000, x);
		xm(2'h2, CIT_OP_XRD_R1, 8'h40, 16'h0000, 8'hE5);
		xm(2'h0, CIT_OP_XWR_DPTR, 8'h00, 16'h0040, 8'hE5);
		xm(2'h0, CIT_OP_CODERD_DPTR, 8'h00, 16'h0041 - 16'h00E5, x);
		xm(2'h0, CIT_OP_XRD_DPTR, 8'h00, 16'h0040, 8'hE5);
		xm(2'h0, CIT_OP_CODERD_PC, 8'h00, 16'h00A3, x);
	endtask
	always @(posedge mclk) begin
		tick++;
		if (tick == 4000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		chk("rst_acc", acc, 8'h00);
		chk("rst_ready", ins_ready, 1'b1);
		rstn <= 1'b1;
		t_branch;
		t_arith;
		t_incdec;
		t_carry;
		t_branch;
		t_xmove;
		t_foreign;
		final_report();
	end
endmodule
